//--- core/pcsa_pkg.sv
package pcsa_pkg;

    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [11:0] VEC_EXT_ONE = 12'h002;
    localparam logic [11:0] VEC_SERIAL = 12'h004;
    localparam logic [11:0] VEC_TIMER_ONE = 12'h006;
    localparam logic [11:0] VEC_TIMER_TWO = 12'h008;
    localparam logic [11:0] VEC_DIVIDER = 12'h00A;
    localparam logic [11:0] VEC_EXT_TWO = 12'h00C;
    localparam logic [11:0] TABLE_BASE = 12'hFE0;
    localparam logic [11:0] HALF_ROM_MASK = 12'h7FF;
    localparam logic [2:0] SHORT_CALL_LSB = 3'h6;

    localparam logic [7:0] ADDR_STACK_LEVEL = 8'hFF;
    localparam logic [7:0] ADDR_DC_LOW = 8'hFC;
    localparam logic [7:0] SMALL_RAM_MASK = 8'h7F;
    localparam logic [1:0] SP_TOP = 2'h3;
    localparam logic [1:0] SP_LOW = 2'h0;

    localparam logic [1:0] CNT_STEP = 2'h1;
    localparam logic [1:0] LAST_STACK_WORD = 2'h3;
    localparam logic [1:0] LAST_DC_NIBBLE = 2'h2;
    localparam logic [3:0] LEVEL_STEP = 4'h1;
    localparam logic [11:0] DC_STEP = 12'h001;
    localparam logic [3:0] PAGE_RESET = 4'h0;
    localparam logic [3:0] OFFSET_RESET = 4'h0;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam int PIN_COUNT = 16;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADVANCE,
        OP_IN_PAGE_BRANCH,
        OP_CALL,
        OP_SHORT_VECTOR_JUMP,
        OP_IRQ,
        OP_RETURN_PLAIN,
        OP_RETURN_FROM_IRQ,
        OP_ROM_HIGH_NIBBLE_LOAD,
        OP_ROM_LOW_NIBBLE_LOAD,
        OP_TABLE_BYTE_OUTPUT,
        OP_SET_PAGE,
        OP_SET_OFFSET,
        OP_RAM_PAGED,
        OP_RAM_DIRECT
    } pcsa_op_t;

    typedef enum logic [2:0] {
        IRQ_EXT_ONE,
        IRQ_SERIAL,
        IRQ_TIMER_ONE,
        IRQ_TIMER_TWO,
        IRQ_DIVIDER,
        IRQ_EXT_TWO
    } pcsa_irq_t;

endpackage

//--- core/pcsa_ram_if.sv
`timescale 1ns/1ps
interface pcsa_ram_if;
    logic load;
    logic use_imm;
    logic [7:0] imm;
    logic page_we;
    logic offset_we;
    logic [3:0] nibble;
    logic small_ram;
    logic [7:0] buffer;
    logic [3:0] page;
    logic [3:0] offset;
    logic [15:0] pin_sel;

    modport ctl (
        output load,
        output use_imm,
        output imm,
        output page_we,
        output offset_we,
        output nibble,
        output small_ram,
        input buffer,
        input page,
        input offset,
        input pin_sel
    );

    modport unit (
        input load,
        input use_imm,
        input imm,
        input page_we,
        input offset_we,
        input nibble,
        input small_ram,
        output buffer,
        output page,
        output offset,
        output pin_sel
    );
endinterface

//--- core/pcsa_ram_addr.sv
`timescale 1ns/1ps
module pcsa_ram_addr
    import pcsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    pcsa_ram_if.unit ra
);

    logic [3:0] ram_page_reg_q;
    logic [3:0] ram_offset_reg_q;
    logic [7:0] ram_addr_buffer_q;
    wire [7:0] buf_src;
    wire [7:0] buf_d;

    // paged pointer or immediate address into the buffer [R17] [R15]
    assign buf_src = ra.use_imm ? ra.imm : {ram_page_reg_q, ram_offset_reg_q};
    // small variant leaves the top address bit undecoded [R15]
    assign buf_d = ra.small_ram ? (buf_src & SMALL_RAM_MASK) : buf_src;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ram_page_reg_q <= PAGE_RESET;
            ram_offset_reg_q <= OFFSET_RESET;
            ram_addr_buffer_q <= BUFFER_RESET;
        end else begin
            if (ra.page_we) begin
                ram_page_reg_q <= ra.nibble;
            end
            if (ra.offset_we) begin
                ram_offset_reg_q <= ra.nibble;
            end
            if (ra.load) begin
                ram_addr_buffer_q <= buf_d; // [R17]
            end
        end
    end

    // offset register picks one port pin for bit operations
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            assign ra.pin_sel[gi] = (ram_offset_reg_q == 4'(gi)); // [R16]
        end
    endgenerate

    assign ra.buffer = ram_addr_buffer_q;
    assign ra.page = ram_page_reg_q;
    assign ra.offset = ram_offset_reg_q;

endmodule

//--- core/pcsa_core.sv
// Functional notes
// R1: 12-bit counter addresses next instruction fetch
// R2: counter advances by instruction length unless loaded
// R3: initialization clears counter to address zero
// R4: pages of 64 words, upper six bits page
// R5: in-page branch replaces low six bits if true
// R6: branch at page end lands next page
// R7: call pushes counter then loads 11-bit target
// R8: rom nibble reads use data counter address
// R9: table output reads byte, drives both ports
// R10: conversion table sits at top 32 addresses
// R11: interrupt vectors fixed at 002 through 00C
// R12: short call jumps to 8n plus 6
// R13: half rom ignores counter msb
// R14: unprogrammed rom words read as zero
// R15: ram pages of 16 words, page/offset
// R16: offset register selects single port pin
// R17: address buffer fed from pointer or immediate
// R18: four ram words per level, call/return restore
// R19: level decremented after push, incremented before pop
// R20: level word at FF, pointer lowest word
// R21: software uses levels E down to 0
// R22: software initializes level word, not hardware
// R23: pointer is 11, level bits, 00
// R24: data counter nibbles live at FC FD FE
// R25: pushed return address is next instruction
`timescale 1ns/1ps
module pcsa_core
    import pcsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic half_rom,
    input wire logic small_ram,
    input wire logic op_valid,
    input pcsa_op_t op,
    output logic op_ready,
    input wire logic [1:0] instr_len,
    input wire logic branch_cond,
    input wire logic [10:0] operand,
    input pcsa_irq_t irq_src,
    input wire logic [3:0] flags_in,
    input wire logic carry_flag,
    input wire logic ram_wr_en_in,
    input wire logic [3:0] ram_wr_data_in,
    output logic [11:0] rom_addr,
    input wire logic [7:0] rom_data,
    output logic [7:0] ram_addr,
    output logic [3:0] ram_wdata,
    output logic ram_we,
    input wire logic [3:0] ram_rdata,
    output logic [11:0] instr_addr_counter,
    output logic [3:0] accumulator,
    output logic accumulator_load,
    output logic [3:0] flags_out,
    output logic flags_load,
    output logic [3:0] port_p1,
    output logic [3:0] port_p2,
    output logic [15:0] pin_sel
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_PUSH_LVL,
        ST_PUSH_WORD,
        ST_PUSH_DEC,
        ST_POP_LVL,
        ST_POP_WORD,
        ST_DC_READ,
        ST_ROM_READ,
        ST_DC_WRITE,
        ST_TBL_NIBBLE,
        ST_TBL_ROM,
        ST_RAM_ACC
    } pcsa_state_t;

    pcsa_state_t state_q;
    pcsa_state_t state_d;
    pcsa_op_t op_q;
    pcsa_op_t op_d;
    logic [11:0] pc_q;
    logic [11:0] pc_d;
    logic [11:0] target_q;
    logic [11:0] target_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [3:0] level_q;
    logic [3:0] level_d;
    logic [11:0] ret_q;
    logic [11:0] ret_d;
    logic [11:0] dc_q;
    logic [11:0] dc_d;
    logic [11:0] tbl_q;
    logic [11:0] tbl_d;
    logic [3:0] acc_q;
    logic [3:0] acc_d;
    logic acc_ld_q;
    logic acc_ld_d;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic flags_ld_q;
    logic flags_ld_d;
    logic [3:0] p1_q;
    logic [3:0] p1_d;
    logic [3:0] p2_q;
    logic [3:0] p2_d;
    logic carry_q;
    logic carry_d;
    logic wr_q;
    logic wr_d;
    logic [3:0] wdata_q;
    logic [3:0] wdata_d;

    pcsa_ram_if ra ();

    pcsa_ram_addr u_ram_addr (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ra(ra.unit)
    );

    wire [11:0] irq_vector;
    wire [11:0] call_target;
    wire [11:0] rom_sel;
    wire [3:0] level_inc;
    wire [3:0] level_dec;
    wire [1:0] cnt_next;
    wire [7:0] dc_nibble_addr;
    wire [7:0] push_word_addr;
    wire [7:0] pop_word_addr;
    wire [3:0] push_word;
    wire [3:0] dc_word;
    wire [3:0] rom_nibble;

    // fixed vector per interrupt source [R11]
    assign irq_vector = (irq_src == IRQ_EXT_ONE) ? VEC_EXT_ONE :
                        (irq_src == IRQ_SERIAL) ? VEC_SERIAL :
                        (irq_src == IRQ_TIMER_ONE) ? VEC_TIMER_ONE :
                        (irq_src == IRQ_TIMER_TWO) ? VEC_TIMER_TWO :
                        (irq_src == IRQ_DIVIDER) ? VEC_DIVIDER : VEC_EXT_TWO;

    // call targets: 11-bit long call [R7], 8n+6 short call [R12]
    assign call_target = (op == OP_CALL) ? {1'b0, operand} :
                         (op == OP_SHORT_VECTOR_JUMP) ?
                         {5'h00, operand[3:0], SHORT_CALL_LSB} : irq_vector;

    // counter msb is not decoded on the half-size rom [R13]
    assign rom_sel = (state_q == ST_ROM_READ) ? dc_q :
                     (state_q == ST_TBL_ROM) ? tbl_q : pc_q;
    assign rom_addr = half_rom ? (rom_sel & HALF_ROM_MASK) : rom_sel; // [R13] [R1]

    assign level_inc = ram_rdata + LEVEL_STEP;
    assign level_dec = level_q - LEVEL_STEP;
    assign cnt_next = cnt_q + CNT_STEP;
    assign dc_nibble_addr = ADDR_DC_LOW + {6'h00, cnt_next}; // [R24]
    // stack pointer: top bits 11, level, word index from 00 [R23] [R20]
    assign push_word_addr = {SP_TOP, level_q, cnt_next};
    assign pop_word_addr = {SP_TOP, level_q, cnt_next};

    // four words per level: three counter nibbles then flags [R18]
    assign push_word = (cnt_q == LAST_STACK_WORD) ? flags_in :
                       (cnt_q == LAST_DC_NIBBLE) ? ret_q[11:8] :
                       (cnt_q == CNT_STEP) ? ret_q[7:4] : ret_q[3:0];
    assign dc_word = dc_q[{cnt_q, 2'b00} +: 4];
    // unprogrammed words come back as zero from the array itself [R14]
    assign rom_nibble = (op_q == OP_ROM_HIGH_NIBBLE_LOAD) ? rom_data[7:4] : rom_data[3:0];

    assign ra.nibble = operand[3:0];
    assign ra.small_ram = small_ram;
    assign ram_addr = ra.buffer;
    assign pin_sel = ra.pin_sel;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        pc_d = pc_q;
        target_d = target_q;
        cnt_d = cnt_q;
        level_d = level_q;
        ret_d = ret_q;
        dc_d = dc_q;
        tbl_d = tbl_q;
        acc_d = acc_q;
        acc_ld_d = 1'b0;
        flags_d = flags_q;
        flags_ld_d = 1'b0;
        p1_d = p1_q;
        p2_d = p2_q;
        carry_d = carry_q;
        wr_d = wr_q;
        wdata_d = wdata_q;
        ra.load = 1'b0;
        ra.use_imm = 1'b1;
        ra.imm = ADDR_STACK_LEVEL;
        ra.page_we = 1'b0;
        ra.offset_we = 1'b0;
        ram_we = 1'b0;
        ram_wdata = 4'h0;
        case (state_q)
            ST_IDLE: begin
                if (op_valid) begin
                    op_d = op;
                    case (op)
                        OP_ADVANCE: begin
                            pc_d = pc_q + {10'h000, instr_len}; // [R2]
                        end
                        OP_IN_PAGE_BRANCH: begin
                            // upper bits already advanced, so page end goes on [R6] [R4]
                            if (branch_cond) begin
                                pc_d = {pc_q[11:6], operand[5:0]}; // [R5]
                            end
                        end
                        OP_CALL, OP_SHORT_VECTOR_JUMP, OP_IRQ: begin
                            target_d = call_target;
                            ret_d = pc_q; // [R25]
                            ra.load = 1'b1; // [R20]
                            state_d = ST_PUSH_LVL;
                        end
                        OP_RETURN_PLAIN, OP_RETURN_FROM_IRQ: begin
                            ra.load = 1'b1; // [R20]
                            state_d = ST_POP_LVL;
                        end
                        OP_ROM_HIGH_NIBBLE_LOAD, OP_ROM_LOW_NIBBLE_LOAD: begin
                            ra.imm = ADDR_DC_LOW; // [R24]
                            ra.load = 1'b1;
                            cnt_d = 2'h0;
                            state_d = ST_DC_READ;
                        end
                        OP_TABLE_BYTE_OUTPUT: begin
                            ra.use_imm = 1'b0; // [R9]
                            ra.load = 1'b1;
                            carry_d = carry_flag;
                            state_d = ST_TBL_NIBBLE;
                        end
                        OP_SET_PAGE: begin
                            ra.page_we = 1'b1; // [R15]
                        end
                        OP_SET_OFFSET: begin
                            ra.offset_we = 1'b1; // [R15]
                        end
                        OP_RAM_PAGED, OP_RAM_DIRECT: begin
                            ra.use_imm = (op == OP_RAM_DIRECT); // [R17]
                            ra.imm = operand[7:0];
                            ra.load = 1'b1;
                            wr_d = ram_wr_en_in;
                            wdata_d = ram_wr_data_in;
                            state_d = ST_RAM_ACC;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_PUSH_LVL: begin
                level_d = ram_rdata;
                ra.imm = {SP_TOP, ram_rdata, SP_LOW}; // [R23]
                ra.load = 1'b1;
                cnt_d = 2'h0;
                state_d = ST_PUSH_WORD;
            end
            ST_PUSH_WORD: begin
                ram_we = 1'b1; // [R18]
                ram_wdata = push_word;
                ra.load = 1'b1;
                cnt_d = cnt_next;
                if (cnt_q == LAST_STACK_WORD) begin
                    ra.imm = ADDR_STACK_LEVEL;
                    state_d = ST_PUSH_DEC;
                end else begin
                    ra.imm = push_word_addr;
                end
            end
            ST_PUSH_DEC: begin
                ram_we = 1'b1;
                ram_wdata = level_dec; // [R19]
                pc_d = target_q; // [R7] [R12] [R11]
                state_d = ST_IDLE;
            end
            ST_POP_LVL: begin
                ram_we = 1'b1;
                ram_wdata = level_inc; // [R19]
                level_d = level_inc;
                ra.imm = {SP_TOP, level_inc, SP_LOW}; // [R23]
                ra.load = 1'b1;
                cnt_d = 2'h0;
                state_d = ST_POP_WORD;
            end
            ST_POP_WORD: begin
                cnt_d = cnt_next;
                if (cnt_q == LAST_STACK_WORD) begin
                    pc_d = ret_q; // [R18]
                    if (op_q == OP_RETURN_FROM_IRQ) begin
                        flags_d = ram_rdata; // [R18]
                        flags_ld_d = 1'b1;
                    end
                    state_d = ST_IDLE;
                end else begin
                    ret_d[{cnt_q, 2'b00} +: 4] = ram_rdata;
                    ra.imm = pop_word_addr;
                    ra.load = 1'b1;
                end
            end
            ST_DC_READ: begin
                dc_d[{cnt_q, 2'b00} +: 4] = ram_rdata; // [R24]
                cnt_d = cnt_next;
                if (cnt_q == LAST_DC_NIBBLE) begin
                    state_d = ST_ROM_READ;
                end else begin
                    ra.imm = dc_nibble_addr;
                    ra.load = 1'b1;
                end
            end
            ST_ROM_READ: begin
                acc_d = rom_nibble; // [R8]
                acc_ld_d = 1'b1;
                state_d = ST_IDLE;
                if (op_q == OP_ROM_HIGH_NIBBLE_LOAD) begin
                    dc_d = dc_q + DC_STEP;
                    ra.imm = ADDR_DC_LOW;
                    ra.load = 1'b1;
                    cnt_d = 2'h0;
                    state_d = ST_DC_WRITE;
                end
            end
            ST_DC_WRITE: begin
                ram_we = 1'b1;
                ram_wdata = dc_word; // [R24]
                cnt_d = cnt_next;
                if (cnt_q == LAST_DC_NIBBLE) begin
                    state_d = ST_IDLE;
                end else begin
                    ra.imm = dc_nibble_addr;
                    ra.load = 1'b1;
                end
            end
            ST_TBL_NIBBLE: begin
                tbl_d = TABLE_BASE + {7'h00, carry_q, ram_rdata}; // [R10] [R9]
                state_d = ST_TBL_ROM;
            end
            ST_TBL_ROM: begin
                p2_d = rom_data[7:4]; // [R9]
                p1_d = rom_data[3:0];
                state_d = ST_IDLE;
            end
            ST_RAM_ACC: begin
                ram_we = wr_q;
                ram_wdata = wdata_q;
                if (!wr_q) begin
                    acc_d = ram_rdata;
                    acc_ld_d = 1'b1;
                end
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            pc_q <= RESET_VECTOR; // [R3]
            target_q <= RESET_VECTOR;
            cnt_q <= 2'h0;
            level_q <= 4'h0;
            ret_q <= 12'h000;
            dc_q <= 12'h000;
            tbl_q <= TABLE_BASE;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            pc_q <= pc_d;
            target_q <= target_d;
            cnt_q <= cnt_d;
            level_q <= level_d;
            ret_q <= ret_d;
            dc_q <= dc_d;
            tbl_q <= tbl_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= 4'h0;
            acc_ld_q <= 1'b0;
            flags_q <= 4'h0;
            flags_ld_q <= 1'b0;
            p1_q <= 4'h0;
            p2_q <= 4'h0;
            carry_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= 4'h0;
        end else begin
            acc_q <= acc_d;
            acc_ld_q <= acc_ld_d;
            flags_q <= flags_d;
            flags_ld_q <= flags_ld_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
            carry_q <= carry_d;
            wr_q <= wr_d;
            wdata_q <= wdata_d;
        end
    end

    assign op_ready = (state_q == ST_IDLE);
    assign instr_addr_counter = pc_q;
    assign accumulator = acc_q;
    assign accumulator_load = acc_ld_q;
    assign flags_out = flags_q;
    assign flags_load = flags_ld_q;
    assign port_p1 = p1_q;
    assign port_p2 = p2_q;

endmodule

//--- verif/pcsa_mem_model.sv
`timescale 1ns/1ps
module pcsa_mem_model (
    input wire logic sys_clk,
    input wire logic [11:0] rom_addr,
    output logic [7:0] rom_data,
    input wire logic [7:0] ram_addr,
    input wire logic [3:0] ram_wdata,
    input wire logic ram_we,
    output logic [3:0] ram_rdata
);
    logic [7:0] rom [0:4095];
    logic [3:0] ram [0:255];
    initial begin
        for (int i = 0; i < 4096; i++) rom[i] = 8'h00; // blank words read as no-op
    end
    assign rom_data = rom[rom_addr]; // fetch at counter address
    assign ram_rdata = ram[ram_addr]; // word at address buffer
    always_ff @(posedge sys_clk) begin
        if (ram_we) begin
            ram[ram_addr] <= ram_wdata;
        end
    end
endmodule

//--- verif/pcsa_checker.sv
`timescale 1ns/1ps
module pcsa_checker
    import pcsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic half_rom,
    input wire logic small_ram,
    input wire logic op_valid,
    input pcsa_op_t op,
    input wire logic op_ready,
    input wire logic [1:0] instr_len,
    input wire logic branch_cond,
    input wire logic [10:0] operand,
    input pcsa_irq_t irq_src,
    input wire logic [11:0] rom_addr,
    input wire logic [7:0] ram_addr,
    input wire logic ram_we,
    input wire logic [11:0] instr_addr_counter,
    input wire logic flags_load,
    input wire logic [15:0] pin_sel
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire take = op_valid && op_ready;
    wire [11:0] adv_d = instr_addr_counter + {10'h000, instr_len};
    wire [5:0] low_d = branch_cond ? operand[5:0] : instr_addr_counter[5:0];
    wire [11:0] brn_d = {instr_addr_counter[11:6], low_d};
    wire [11:0] tgt_d = (op == OP_CALL) ? {1'b0, operand} :
        (op == OP_IRQ) ? {8'h00, irq_src, 1'b0} + 12'h002 :
        {5'h00, operand[3:0], 3'h6};
    pcsa_op_t kind_q;
    logic [11:0] tgt_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            kind_q <= OP_NONE;
            tgt_q <= 12'h000;
        end else if (take) begin
            kind_q <= op;
            tgt_q <= tgt_d;
        end
    end
    chk_reset_pc: assert property ($rose(rstn) |-> instr_addr_counter == 12'h000)
        else $error("reset counter wrong");
    chk_advance_len: assert property (take && op == OP_ADVANCE |=>
        op_ready && instr_addr_counter == $past(adv_d))
        else $error("advance wrong");
    chk_branch_low: assert property (take && op == OP_IN_PAGE_BRANCH |=>
        instr_addr_counter == $past(brn_d))
        else $error("branch wrong");
    chk_jump_target: assert property ($rose(op_ready) &&
        kind_q inside {OP_CALL, OP_IRQ, OP_SHORT_VECTOR_JUMP} |-> instr_addr_counter == tgt_q)
        else $error("jump target wrong");
    chk_call_busy: assert property (take && op == OP_CALL |=> !op_ready [*6] ##1 op_ready)
        else $error("call length wrong");
    chk_romhi_busy: assert property (take && op == OP_ROM_HIGH_NIBBLE_LOAD |=>
        !op_ready [*7] ##1 op_ready)
        else $error("rom high length");
    chk_stack_slot: assert property (take && op == OP_CALL && !small_ram |->
        ##[1:4] ram_we && ram_addr[7:6] == 2'h3 && ram_addr[1:0] == 2'h0)
        else $error("stack slot wrong");
    chk_table_addr: assert property (take && op == OP_TABLE_BYTE_OUTPUT && !half_rom |->
        ##[1:3] rom_addr[11:5] == 7'h7F)
        else $error("table address");
    chk_half_rom: assert property (half_rom |-> !rom_addr[11])
        else $error("rom msb decoded");
    chk_pin_onehot: assert property ($onehot(pin_sel))
        else $error("pin not one-hot");
    chk_flags_ret: assert property (flags_load |->
        kind_q == OP_RETURN_FROM_IRQ || $past(kind_q) == OP_RETURN_FROM_IRQ)
        else $error("stray flags restore");
    cov_call: cover property (take && op == OP_CALL);
    cov_irq: cover property (take && op == OP_IRQ);
    cov_table: cover property (take && op == OP_TABLE_BYTE_OUTPUT);
endmodule

//--- verif/cpu_pc_stack_addressing_test.sv
`timescale 1ns/1ps
bind pcsa_core pcsa_checker i_chk (.sys_clk, .rstn, .half_rom, .small_ram, .op_valid, .op,
    .op_ready, .instr_len, .branch_cond, .operand, .irq_src, .rom_addr, .ram_addr, .ram_we,
    .instr_addr_counter, .flags_load, .pin_sel);
module cpu_pc_stack_addressing_test;
    import pcsa_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic half_rom = 1'b0;
    logic small_ram = 1'b0;
    logic op_valid = 1'b0;
    pcsa_op_t op = OP_NONE;
    logic op_ready;
    logic [1:0] instr_len = 2'h0;
    logic branch_cond = 1'b0;
    logic [10:0] operand = 11'h000;
    pcsa_irq_t irq_src = IRQ_EXT_ONE;
    logic [3:0] flags_in = 4'h0;
    logic carry_flag = 1'b0;
    logic ram_wr_en_in = 1'b0;
    logic [3:0] ram_wr_data_in = 4'h0;
    logic [11:0] rom_addr;
    logic [7:0] rom_data;
    logic [7:0] ram_addr;
    logic [3:0] ram_wdata;
    logic ram_we;
    logic [3:0] ram_rdata;
    logic [11:0] instr_addr_counter;
    logic [3:0] accumulator;
    logic accumulator_load;
    logic [3:0] flags_out;
    logic [3:0] port_p1;
    logic [3:0] port_p2;
    logic [15:0] pin_sel;
    int fail_count = 0;
    int cmp_count = 0;
    pcsa_core i_dut (.sys_clk, .rstn, .half_rom, .small_ram, .op_valid, .op, .op_ready,
        .instr_len, .branch_cond, .operand, .irq_src, .flags_in, .carry_flag, .ram_wr_en_in,
        .ram_wr_data_in, .rom_addr, .rom_data, .ram_addr, .ram_wdata, .ram_we, .ram_rdata,
        .instr_addr_counter, .accumulator, .accumulator_load, .flags_out, .flags_load(),
        .port_p1, .port_p2, .pin_sel);
    pcsa_mem_model i_mem (.sys_clk, .rom_addr, .rom_data, .ram_addr, .ram_wdata, .ram_we,
        .ram_rdata);
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic run(input pcsa_op_t o, input logic [10:0] a);
        int n;
        op = o;
        operand = a;
        op_valid = 1'b1;
        step();
        op_valid = 1'b0;
        n = 0;
        do begin
            step();
            n++;
        end while (op_ready !== 1'b1 && n < 40);
        if (n == 40) begin
            fail_count++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        ram_wr_en_in = 1'b1;
        ram_wr_data_in = d;
        run(OP_RAM_DIRECT, {3'h0, a});
    endtask
    task automatic t_call;
        wr(8'hFF, 4'hC); // level set by startup code
        instr_len = 2'h2;
        run(OP_ADVANCE, 11'h000);
        instr_len = 2'h1;
        run(OP_ADVANCE, 11'h000);
        chk(instr_addr_counter, 16'h0003);
        flags_in = 4'h9;
        run(OP_CALL, 11'h123);
        chk(instr_addr_counter, 16'h0123);
        chk(i_mem.ram[8'hF0], 16'h3);
        chk(i_mem.ram[8'hF1], 16'h0);
        chk(i_mem.ram[8'hF3], 16'h9);
        chk(i_mem.ram[8'hFF], 16'hB);
        run(OP_RETURN_PLAIN, 11'h000);
        chk(instr_addr_counter, 16'h0003);
        chk(i_mem.ram[8'hFF], 16'hC);
        run(OP_CALL, 11'h7FF);
        chk(instr_addr_counter, 16'h07FF);
        run(OP_RETURN_PLAIN, 11'h000);
    endtask
    task automatic t_branch;
        run(OP_CALL, 11'h03F);
        run(OP_ADVANCE, 11'h000);
        chk(instr_addr_counter, 16'h0040);
        branch_cond = 1'b1;
        run(OP_IN_PAGE_BRANCH, 11'h005);
        chk(instr_addr_counter, 16'h0045);
        branch_cond = 1'b0;
        run(OP_IN_PAGE_BRANCH, 11'h03A);
        chk(instr_addr_counter, 16'h0045);
        run(OP_RETURN_PLAIN, 11'h000);
    endtask
    task automatic t_irq;
        for (int s = 0; s < 6; s++) begin
            flags_in = 4'(s);
            irq_src = pcsa_irq_t'(s);
            run(OP_IRQ, 11'h000);
            chk(instr_addr_counter, 16'(2 + 2 * s));
            flags_in = 4'hF;
            run(OP_RETURN_FROM_IRQ, 11'h000);
            step();
            chk(flags_out, 16'(s));
            chk(instr_addr_counter, 16'h0003);
        end
        for (int n = 1; n < 16; n += 14) begin
            run(OP_SHORT_VECTOR_JUMP, 11'(n));
            chk(instr_addr_counter, 16'(8 * n + 6));
            run(OP_RETURN_PLAIN, 11'h000);
        end
    endtask
    task automatic t_rom;
        wr(8'hFC, 4'h3);
        wr(8'hFD, 4'h2);
        wr(8'hFE, 4'h1);
        run(OP_ROM_HIGH_NIBBLE_LOAD, 11'h000);
        step();
        chk(accumulator, 16'hA);
        chk(i_mem.ram[8'hFC], 16'h4);
        run(OP_ROM_LOW_NIBBLE_LOAD, 11'h000);
        chk(accumulator_load, 16'h1);
        step();
        chk(accumulator, 16'hC);
    endtask
    task automatic t_table;
        run(OP_SET_PAGE, 11'h003);
        run(OP_SET_OFFSET, 11'h007);
        chk(pin_sel, 16'h0080);
        ram_wr_en_in = 1'b1;
        ram_wr_data_in = 4'h5;
        run(OP_RAM_PAGED, 11'h000);
        ram_wr_en_in = 1'b0;
        chk(i_mem.ram[8'h37], 16'h5);
        run(OP_RAM_PAGED, 11'h000);
        chk(accumulator, 16'h5);
        carry_flag = 1'b1;
        run(OP_TABLE_BYTE_OUTPUT, 11'h000);
        step();
        chk({port_p2, port_p1}, 16'h3C);
        half_rom = 1'b1;
        run(OP_TABLE_BYTE_OUTPUT, 11'h000);
        step();
        chk({port_p2, port_p1}, 16'hE1);
        half_rom = 1'b0;
        small_ram = 1'b1;
        wr(8'hC1, 4'h6);
        chk(i_mem.ram[8'h41], 16'h6);
        small_ram = 1'b0;
    endtask
    initial begin
        #1;
        i_mem.rom[12'h123] = 8'hA5;
        i_mem.rom[12'h124] = 8'h5C;
        i_mem.rom[12'hFF5] = 8'h3C;
        i_mem.rom[12'h7F5] = 8'hE1;
        repeat (10) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        chk(instr_addr_counter, 16'h0000);
        chk(pin_sel, 16'h0001);
        t_call();
        t_branch();
        t_irq();
        t_rom();
        t_table();
        results();
    end
endmodule
